// file: gdpm_top.sv
// Gate drive mode decoder: pin inputs to six gate commands, with dead time and brake.
// Assumes an APB master on pclk and asynchronous pin inputs from a PWM timer.
`timescale 1ns/1ns
`include "gdpm_params.svh"

module gdpm_top
   import gdpm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] high_side_input,
   input wire logic [2:0] low_side_input,
   input wire logic brake_request_n,
   output logic [2:0] high_gate_out,
   output logic [2:0] low_gate_out
);

   localparam logic [9:0] BRAKE_ALT_LAST = 10'(`GDPM_BRAKE_ALT_CYC - 1);

   // ==========================================
   // Register state
   logic [2:0] mode_q, mode_d;
   logic freewheel_select_q, freewheel_select_d;
   logic [1:0] brake_action_q, brake_action_d;
   logic [7:0] rise_dead_time_q, rise_dead_time_d;
   logic [7:0] fall_dead_time_q, fall_dead_time_d;
   logic [31:0] prdata_q, prdata_d;
   logic [31:0] status_word;
   logic acc_write;
   logic addr_hit;

   // ==========================================
   // Input synchroniser state
   logic [6:0] pin_raw;
   logic [6:0] sync1_q, sync2_q, sync3_q;
   logic [6:0] pin_q, pin_d;

   // ==========================================
   // Decode signals
   logic [2:0] hi_in;
   logic [2:0] lo_in;
   logic brake_n;
   logic duty_input_a;
   logic [2:0] pattern_code;
   logic twelve_step_select;
   gdpm_dec_t dec;
   gdpm_role_t role [3];
   logic [2:0] req_hi, req_lo;

   // ==========================================
   // Brake alternation state
   logic [9:0] alt_cnt_q, alt_cnt_d;
   logic alt_high_q, alt_high_d;

   // ==========================================
   // Gate state
   logic [2:0] hi_q, hi_d, lo_q, lo_d;
   logic [7:0] off_cnt_q [3];
   logic [7:0] off_cnt_d [3];

   // ==========================================
   // APB slave, zero wait states
   assign pready = 1'b1;
   assign addr_hit = (paddr == `GDPM_ADDR_CTRL) || (paddr == `GDPM_ADDR_DEAD) || (paddr == `GDPM_ADDR_STAT);
   assign pslverr = psel & penable & ~addr_hit;
   assign acc_write = psel & penable & pwrite;
   assign prdata = prdata_q;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`GDPM_ST_HIGH_LSB +: 3] = hi_q;
      status_word[`GDPM_ST_LOW_LSB +: 3] = lo_q;
      status_word[`GDPM_ST_PAT_LSB +: 3] = pattern_code;
      status_word[`GDPM_ST_TWELVE_BIT] = twelve_step_select;
      status_word[`GDPM_ST_BRAKE_BIT] = ~brake_n;
      status_word[`GDPM_ST_THREE_BIT] = (dec == GDPM_DEC_THREE);
      status_word[`GDPM_ST_SINGLE_BIT] = (dec == GDPM_DEC_SINGLE);
   end

   always_comb begin
      mode_d = mode_q;
      freewheel_select_d = freewheel_select_q;
      brake_action_d = brake_action_q;
      rise_dead_time_d = rise_dead_time_q;
      fall_dead_time_d = fall_dead_time_q;
      prdata_d = prdata_q;
      // Read data captured in the setup cycle
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `GDPM_ADDR_CTRL: begin
               prdata_d = 32'h0000_0000;
               prdata_d[`GDPM_MODE_MSB:`GDPM_MODE_LSB] = mode_q;
               prdata_d[`GDPM_FREEW_BIT] = freewheel_select_q;
               prdata_d[`GDPM_BRK_MSB:`GDPM_BRK_LSB] = brake_action_q;
            end
            `GDPM_ADDR_DEAD: begin
               prdata_d = 32'h0000_0000;
               prdata_d[`GDPM_RISE_MSB:`GDPM_RISE_LSB] = rise_dead_time_q;
               prdata_d[`GDPM_FALL_MSB:`GDPM_FALL_LSB] = fall_dead_time_q;
            end
            `GDPM_ADDR_STAT: begin
               prdata_d = status_word;
            end
            default: begin
               prdata_d = 32'h0000_0000;
            end
         endcase
      end
      if (acc_write && paddr == `GDPM_ADDR_CTRL) begin
         if (pstrb[0]) begin
            mode_d = pwdata[`GDPM_MODE_MSB:`GDPM_MODE_LSB];
            freewheel_select_d = pwdata[`GDPM_FREEW_BIT];
         end
         if (pstrb[1]) begin
            brake_action_d = pwdata[`GDPM_BRK_MSB:`GDPM_BRK_LSB];
         end
      end
      if (acc_write && paddr == `GDPM_ADDR_DEAD) begin
         if (pstrb[0]) begin
            rise_dead_time_d = pwdata[`GDPM_RISE_MSB:`GDPM_RISE_LSB];
         end
         if (pstrb[1]) begin
            fall_dead_time_d = pwdata[`GDPM_FALL_MSB:`GDPM_FALL_LSB];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= `GDPM_RST_MODE;
         freewheel_select_q <= `GDPM_RST_FREEW;
         brake_action_q <= `GDPM_RST_BRK;
         rise_dead_time_q <= `GDPM_RST_RISE;
         fall_dead_time_q <= `GDPM_RST_FALL;
         prdata_q <= 32'h0000_0000;
      end else begin
         mode_q <= mode_d;
         freewheel_select_q <= freewheel_select_d;
         brake_action_q <= brake_action_d;
         rise_dead_time_q <= rise_dead_time_d;
         fall_dead_time_q <= fall_dead_time_d;
         prdata_q <= prdata_d;
      end
   end

   // ==========================================
   // Pin synchronisers, change taken once stages two and three agree
   assign pin_raw = {brake_request_n, low_side_input, high_side_input};

   always_comb begin
      for (int i = 0; i < 7; i++) begin
         pin_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : pin_q[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 7'h40;
         sync2_q <= 7'h40;
         sync3_q <= 7'h40;
         pin_q <= 7'h40;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_q <= pin_d;
      end
   end

   assign hi_in = pin_q[2:0];
   assign lo_in = pin_q[5:3];
   assign brake_n = pin_q[6];

   assign duty_input_a = hi_in[0];
   assign pattern_code = {lo_in[0], hi_in[1], lo_in[1]};
   assign twelve_step_select = hi_in[2];

   // ==========================================
   // Mode decode
   always_comb begin
      unique case (mode_q)
         `GDPM_MODE_THREE: dec = GDPM_DEC_THREE;
         `GDPM_MODE_SINGLE: dec = GDPM_DEC_SINGLE;
         default: dec = GDPM_DEC_IDLE;
      endcase
   end

   // ==========================================
   // Commutation state table
   always_comb begin
      role[0] = GDPM_ROLE_OFF;
      role[1] = GDPM_ROLE_OFF;
      role[2] = GDPM_ROLE_OFF;
      unique case (pattern_code)
         3'h3: begin
            role[0] = GDPM_ROLE_MOD;
            role[1] = GDPM_ROLE_SINK;
            role[2] = twelve_step_select ? GDPM_ROLE_SINK : GDPM_ROLE_OFF;
         end
         3'h2: begin
            role[0] = twelve_step_select ? GDPM_ROLE_MOD : GDPM_ROLE_OFF;
            role[1] = GDPM_ROLE_SINK;
            role[2] = GDPM_ROLE_MOD;
         end
         3'h6: begin
            role[0] = GDPM_ROLE_SINK;
            role[1] = twelve_step_select ? GDPM_ROLE_SINK : GDPM_ROLE_OFF;
            role[2] = GDPM_ROLE_MOD;
         end
         3'h4: begin
            role[0] = GDPM_ROLE_SINK;
            role[1] = GDPM_ROLE_MOD;
            role[2] = twelve_step_select ? GDPM_ROLE_MOD : GDPM_ROLE_OFF;
         end
         3'h5: begin
            role[0] = twelve_step_select ? GDPM_ROLE_SINK : GDPM_ROLE_OFF;
            role[1] = GDPM_ROLE_MOD;
            role[2] = GDPM_ROLE_SINK;
         end
         3'h1: begin
            role[0] = GDPM_ROLE_MOD;
            role[1] = twelve_step_select ? GDPM_ROLE_MOD : GDPM_ROLE_OFF;
            role[2] = GDPM_ROLE_SINK;
         end
         3'h7: begin
            role[0] = GDPM_ROLE_MOD;
            role[1] = GDPM_ROLE_SINK;
            role[2] = GDPM_ROLE_SINK;
         end
         3'h0: begin
            role[0] = GDPM_ROLE_OFF;
            role[1] = GDPM_ROLE_OFF;
            role[2] = GDPM_ROLE_OFF;
         end
      endcase
   end

   // ==========================================
   // Brake alternation timer
   always_comb begin
      alt_cnt_d = 10'h000;
      alt_high_d = 1'b0;
      if (!brake_n && brake_action_q == `GDPM_BRK_ALTERNATE) begin
         alt_high_d = alt_high_q;
         if (alt_cnt_q == BRAKE_ALT_LAST) begin
            alt_cnt_d = 10'h000;
            alt_high_d = ~alt_high_q;
         end else begin
            alt_cnt_d = alt_cnt_q + 10'h001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alt_cnt_q <= 10'h000;
         alt_high_q <= 1'b0;
      end else begin
         alt_cnt_q <= alt_cnt_d;
         alt_high_q <= alt_high_d;
      end
   end

   // ==========================================
   // Gate requests before dead time
   always_comb begin
      req_hi = 3'h0;
      req_lo = 3'h0;
      if (!brake_n) begin
         unique case (brake_action_q)
            `GDPM_BRK_LOW_ON: req_lo = 3'h7;
            `GDPM_BRK_HIGH_ON: req_hi = 3'h7;
            `GDPM_BRK_ALTERNATE: begin
               req_hi = alt_high_q ? 3'h7 : 3'h0;
               req_lo = alt_high_q ? 3'h0 : 3'h7;
            end
            `GDPM_BRK_FLOAT: begin
               req_hi = 3'h0;
               req_lo = 3'h0;
            end
         endcase
      end else if (dec == GDPM_DEC_THREE) begin
         for (int p = 0; p < 3; p++) begin
            req_hi[p] = ~lo_in[p] & hi_in[p];
            req_lo[p] = ~lo_in[p] & ~hi_in[p];
         end
      end else if (dec == GDPM_DEC_SINGLE) begin
         for (int p = 0; p < 3; p++) begin
            unique case (role[p])
               GDPM_ROLE_MOD: begin
                  req_hi[p] = duty_input_a;
                  req_lo[p] = ~duty_input_a & ~freewheel_select_q;
               end
               GDPM_ROLE_SINK: req_lo[p] = 1'b1;
               GDPM_ROLE_OFF: begin
                  req_hi[p] = 1'b0;
                  req_lo[p] = 1'b0;
               end
            endcase
         end
      end
   end

   // ==========================================
   // Dead time insertion per phase
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         hi_d[p] = req_hi[p] & (hi_q[p] | (~lo_q[p] & (off_cnt_q[p] >= rise_dead_time_q)));
         lo_d[p] = req_lo[p] & (lo_q[p] | (~hi_q[p] & (off_cnt_q[p] >= fall_dead_time_q)));
         if (hi_q[p] || lo_q[p]) begin
            off_cnt_d[p] = 8'h00;
         end else if (off_cnt_q[p] != 8'hff) begin
            off_cnt_d[p] = off_cnt_q[p] + 8'h01;
         end else begin
            off_cnt_d[p] = off_cnt_q[p];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_q <= 3'h0;
         lo_q <= 3'h0;
         for (int p = 0; p < 3; p++) begin
            off_cnt_q[p] <= 8'h00;
         end
      end else begin
         hi_q <= hi_d;
         lo_q <= lo_d;
         for (int p = 0; p < 3; p++) begin
            off_cnt_q[p] <= off_cnt_d[p];
         end
      end
   end

   assign high_gate_out = hi_q;
   assign low_gate_out = lo_q;

endmodule // gdpm_top

// file: gdpm_params.svh
// Constants of the gate drive mode decoder: register map, fields, reset values, timing.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef GDPM_PARAMS_SVH
`define GDPM_PARAMS_SVH

// ==========================================
// Register byte addresses
`define GDPM_ADDR_CTRL 12'h000
`define GDPM_ADDR_DEAD 12'h004
`define GDPM_ADDR_STAT 12'h008

// ==========================================
// Control register fields
`define GDPM_MODE_LSB 0
`define GDPM_MODE_MSB 2
`define GDPM_FREEW_BIT 4
`define GDPM_BRK_LSB 8
`define GDPM_BRK_MSB 9

// ==========================================
// Dead time register fields
`define GDPM_RISE_LSB 0
`define GDPM_RISE_MSB 7
`define GDPM_FALL_LSB 8
`define GDPM_FALL_MSB 15

// ==========================================
// Status register fields
`define GDPM_ST_HIGH_LSB 0
`define GDPM_ST_LOW_LSB 3
`define GDPM_ST_PAT_LSB 8
`define GDPM_ST_TWELVE_BIT 11
`define GDPM_ST_BRAKE_BIT 12
`define GDPM_ST_THREE_BIT 13
`define GDPM_ST_SINGLE_BIT 14

// ==========================================
// Field values
`define GDPM_MODE_SIX 3'h0
`define GDPM_MODE_THREE 3'h1
`define GDPM_MODE_SINGLE 3'h2
`define GDPM_MODE_HALL 3'h3
`define GDPM_BRK_LOW_ON 2'h0
`define GDPM_BRK_HIGH_ON 2'h1
`define GDPM_BRK_ALTERNATE 2'h2
`define GDPM_BRK_FLOAT 2'h3

// ==========================================
// Reset values
`define GDPM_RST_MODE 3'h0
`define GDPM_RST_FREEW 1'b1
`define GDPM_RST_BRK 2'h3
`define GDPM_RST_RISE 8'h10
`define GDPM_RST_FALL 8'h10

// ==========================================
// Timing
`define GDPM_CLK_NS 8
`define GDPM_BRAKE_ALT_NS 8000
`define GDPM_BRAKE_ALT_CYC ((`GDPM_BRAKE_ALT_NS + `GDPM_CLK_NS - 1) / `GDPM_CLK_NS)

`endif

// file: gdpm_pkg.sv
// Types shared by the gate drive mode decoder.
// Assumes the constants header sits in the same folder.
package gdpm_pkg;

   // ==========================================
   // Role of one phase in a commutation state
   typedef enum logic [1:0] {
      GDPM_ROLE_OFF,
      GDPM_ROLE_MOD,
      GDPM_ROLE_SINK
   } gdpm_role_t;

   // ==========================================
   // Active decode of the mode field
   typedef enum logic [1:0] {
      GDPM_DEC_IDLE,
      GDPM_DEC_THREE,
      GDPM_DEC_SINGLE
   } gdpm_dec_t;

endpackage

// file: gdpm_chk.sv
// Port checker of the gate drive mode decoder.
// Assumes a bind to gdpm_top and one pclk domain.
`timescale 1ns/1ns
module gdpm_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] high_gate_out,
   input wire logic [2:0] low_gate_out
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ====
   // Gates
   no_shoot_a:
   assert property ((high_gate_out & low_gate_out) == 3'h0)
      else $error("both gates of a phase on");
   high_dead_a:
   assert property (((high_gate_out & ~$past(high_gate_out)) & $past(low_gate_out)) == 3'h0)
      else $error("high gate on straight after low gate");
   low_dead_a:
   assert property (((low_gate_out & ~$past(low_gate_out)) & $past(high_gate_out)) == 3'h0)
      else $error("low gate on straight after high gate");
   // ====
   // Bus
   ready_high_a: // Zero wait
   assert property (pready)
      else $error("pready low");
   err_phase_a: // Error only in access
   assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   err_unmapped_a: // Decode error
   assert property (psel && penable && paddr > 12'h008 |-> pslverr)
      else $error("unmapped access without error");
   err_mapped_a: // Decode ok
   assert property (psel && penable && paddr <= 12'h008 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access flagged");
   unmapped_zero_a: // Read of hole
   assert property (psel && !penable && !pwrite && paddr > 12'h008 |=> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   reserved_zero_a: // Upper bits
   assert property (prdata[31:15] == 17'h0_0000)
      else $error("reserved read bits set");
endmodule // gdpm_chk

bind gdpm_top gdpm_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .high_gate_out(high_gate_out), .low_gate_out(low_gate_out));

// file: gdpm_timer_model.sv
// Model of the PWM timer that feeds the decoder pins.
// Assumes the bench sets mode, pattern and duty; period is 40 cycles.
`timescale 1ns/1ns
module gdpm_timer_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic single_sel,
   input wire logic [2:0] code,
   input wire logic twelve,
   input wire logic unused_c,
   input wire logic [5:0] duty,
   input wire logic [2:0] phase_h,
   input wire logic [2:0] phase_l,
   output logic [2:0] high_side_input,
   output logic [2:0] low_side_input
);
   logic [5:0] cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 6'h00;
         high_side_input <= 3'h0;
         low_side_input <= 3'h0;
      end else begin
         cnt_q <= (cnt_q == 6'h27) ? 6'h00 : cnt_q + 6'h01;
         if (single_sel) begin
            high_side_input <= {twelve, code[1], cnt_q < duty};
            low_side_input <= {unused_c, code[0], code[2]};
         end else begin
            high_side_input <= phase_h;
            low_side_input <= phase_l;
         end
      end
   end
endmodule // gdpm_timer_model

// file: tb_top.sv
// Self-checking bench of the gate drive mode decoder.
// Assumes package, design, timer model and checker compiled first.
`timescale 1ns/1ns
`include "gdpm_params.svh"
module tb_top;
   import gdpm_pkg::*;
   logic pclk = '0;
   logic presetn = '0;
   logic psel = '0, penable = '0, pwrite = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, brake_request_n = '1;
   logic [2:0] high_side_input, low_side_input, high_gate_out, low_gate_out;
   logic single_sel = '0, twelve = '0, unused_c = '0;
   logic [2:0] code = '0, phase_h = '0, phase_l = '0;
   logic [5:0] duty = '0;
   int fails = 0, tests_run = 0, seed = 38448;
   always #4 pclk = ~pclk;
   gdpm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .high_side_input(high_side_input), .low_side_input(low_side_input),
      .brake_request_n(brake_request_n), .high_gate_out(high_gate_out), .low_gate_out(low_gate_out));
   gdpm_timer_model i_timer (.clk(pclk), .rst_n(presetn), .single_sel(single_sel), .code(code),
      .twelve(twelve), .unused_c(unused_c), .duty(duty), .phase_h(phase_h), .phase_l(phase_l),
      .high_side_input(high_side_input), .low_side_input(low_side_input));
   // ====
   // Tasks and expectations
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] ctrl(input logic [2:0] m, input logic fw, input logic [1:0] bk);
      return {22'h0, bk, 3'h0, fw, 1'h0, m};
   endfunction
   function automatic logic [5:0] exp_single(input logic [3:0] tc, input logic fw, input logic d);
      logic [5:0] ms;
      case (tc)
         4'h3: ms = 6'h0a;
         4'h2: ms = 6'h22;
         4'h6: ms = 6'h21;
         4'h4: ms = 6'h11;
         4'h5: ms = 6'h14;
         4'h1: ms = 6'h0c;
         4'ha: ms = 6'h2a;
         4'he: ms = 6'h23;
         4'hc: ms = 6'h31;
         4'hd: ms = 6'h15;
         4'h9: ms = 6'h1c;
         4'h7, 4'hb, 4'hf: ms = 6'h0e;
         default: ms = 6'h00;
      endcase
      return {d ? ms[5:3] : 3'h0, ms[2:0] | (ms[5:3] & {3{~d & ~fw}})};
   endfunction
   // ====
   // Main sequence
   initial begin
      int i, n, hc, lc;
      logic [31:0] r;
      cyc(6);
      presetn <= 1'b1;
      apb(0, `GDPM_ADDR_CTRL, 0);
      check("ctrl reset", rd, 32'h0000_0310);
      apb(0, `GDPM_ADDR_DEAD, 0);
      check("dead reset", rd, 32'h0000_1010);
      apb(1, `GDPM_ADDR_DEAD, 32'hffff_0503);
      apb(0, `GDPM_ADDR_DEAD, 0);
      check("dead", rd, 32'h0000_0503);
      apb(1, 12'h00c, 32'h0000_0001);
      apb(0, 12'h00c, 0);
      check("hole", rd, 0);
      phase_h <= 3'h7;
      for (i = 0; i < 8; i += 3) begin
         apb(1, `GDPM_ADDR_CTRL, ctrl(i[2:0], 1'h1, 2'h3));
         cyc(30);
         check("idle", {high_gate_out, low_gate_out}, 0);
      end
      apb(1, `GDPM_ADDR_CTRL, ctrl(3'h1, 1'h1, 2'h3));
      repeat (24) begin
         r = $random(seed);
         phase_h <= r[2:0];
         phase_l <= r[5:3] & r[8:6];
         cyc(30);
         check("three", {high_gate_out, low_gate_out}, {phase_h & ~phase_l, ~phase_h & ~phase_l});
      end
      apb(0, `GDPM_ADDR_STAT, 0);
      check("three flag", rd[14:13], 2'h1);
      phase_l <= 3'h0;
      phase_h <= 3'h7;
      for (i = 0; i < 2; i++) begin
         cyc(30);
         phase_h <= i ? 3'h7 : 3'h6;
         n = 0;
         while ((i ? low_gate_out[0] : high_gate_out[0]) !== 1'b0 && n < 50) begin
            cyc(1);
            n++;
         end
         n = 0;
         while ((i ? high_gate_out[0] : low_gate_out[0]) !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
         end
         check("dead time", i ? (n >= 3 && n <= 5) : (n >= 5 && n <= 7), 1);
      end
      single_sel <= 1'b1;
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         code <= i[2:0];
         twelve <= i[3];
         unused_c <= r[0];
         duty <= r[1] ? 6'h28 : 6'h00;
         apb(1, `GDPM_ADDR_CTRL, ctrl(3'h2, r[2], 2'h3));
         cyc(40);
         check("single", {high_gate_out, low_gate_out}, exp_single(i[3:0], r[2], r[1]));
      end
      apb(0, `GDPM_ADDR_STAT, 0);
      check("single flag", rd[14:13], 2'h2);
      code <= 3'h7;
      duty <= 6'h14;
      for (i = 0; i < 2; i++) begin
         apb(1, `GDPM_ADDR_CTRL, ctrl(3'h2, i[0], 2'h3));
         cyc(40);
         hc = 0;
         lc = 0;
         repeat (400) begin
            cyc(1);
            hc += high_gate_out[0];
            lc += low_gate_out[0];
         end
         check("pwm high", i ? (hc >= 190 && hc <= 210) : (hc >= 140 && hc <= 180), 1);
         check("pwm low", i ? lc == 0 : (lc >= 120 && lc <= 160), 1);
      end
      code <= 3'h0;
      for (i = 0; i < 4; i++) begin
         apb(1, `GDPM_ADDR_CTRL, ctrl(3'h2, 1'h1, i[1:0]));
         brake_request_n <= 1'b0;
         cyc(30);
         check("brake", {high_gate_out, low_gate_out}, i == 1 ? 6'h38 : i == 3 ? 6'h00 : 6'h07);
         if (i == 2) begin
            cyc(1000);
            check("brake alt", {high_gate_out, low_gate_out}, 6'h38);
         end
         brake_request_n <= 1'b1;
         cyc(30);
         check("stop", {high_gate_out, low_gate_out}, 0);
      end
      report_and_stop();
   end
   initial begin
      cyc(20000);
      fails++;
      report_and_stop();
   end
endmodule // tb_top
